//--- rtl/atc_consts.svh
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// Register indices; byte address is four times the index
`define ATC_IDX_CMD 14'h1800
`define ATC_IDX_WR_LOW 14'h1801
`define ATC_IDX_WR_HIGH 14'h1802
`define ATC_IDX_STATUS 14'h1803
`define ATC_IDX_RD_LOW 14'h1804
`define ATC_IDX_RD_HIGH 14'h1805

// Command bits
`define ATC_CMD_MAKE 2
`define ATC_CMD_FIRST 1
`define ATC_CMD_NEXT 0
`define ATC_CMD_MASK 32'h0000_0007

// Status bits
`define ATC_ST_PENDING 0
`define ATC_ST_NOT_FOUND 1
`define ATC_ST_FULL 2

// Entry fields in the high word
`define ATC_F_VALID 26
`define ATC_F_AGE1 25
`define ATC_F_STATIC 24
`define ATC_F_AGE0 23
`define ATC_F_PRIO_EN 22
`define ATC_F_PRIO_HI 21
`define ATC_F_PRIO_LO 19
`define ATC_F_MAC_HI 15
`define ATC_WR_HIGH_MASK 32'h07ff_ffff

// Reset values
`define ATC_RST_WORD 32'h0000_0000
`define ATC_RST_CMD 3'h0

// Aging sweep period: time in seconds and clock rate in hertz
`define ATC_AGE_SWEEP_S 64'd150
`define ATC_CLK_HZ 64'd250000000
`define ATC_AGE_SWEEP_CYCLES (`ATC_AGE_SWEEP_S * `ATC_CLK_HZ)

`endif

//--- rtl/atc_pkg.sv
package atc_pkg;

    typedef struct packed {
        logic [31:0] high;
        logic [31:0] low;
    } atc_entry_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [15:0] address;
        logic [31:0] writedata;
    } atc_avs_req_s;

    typedef enum logic [1:0] {
        ATC_ST_IDLE = 2'b00,
        ATC_ST_MAKE = 2'b01,
        ATC_ST_GET = 2'b10,
        ATC_ST_AGE = 2'b11
    } atc_state_e;

endpackage

//--- rtl/atc_table_command_port.sv
`timescale 1ns/1ps
`include "atc_consts.svh"

// How it works
// [R1] Command register at index 1800h, 32 bits
// [R2] Any command bit raises pending, runs operation
// [R3] Software sets one command bit per write
// [R4] Fetch clears pending once read words loaded
// [R5] Software loads write words before make
// [R6] Make stores write words where table chooses
// [R7] Make overwrites or removes same-address entry
// [R8] Command bits clear together with pending
// [R9] Writing zero command bits does nothing
// [R10] Get first restarts scan, loads first valid
// [R11] Get next loads next valid entry
// [R12] Software waits for pending low first
// [R13] Low write word holds first MAC bits
// [R14] Valid bit 26; zero invalidates match
// [R15] Static bit 24; others age out
// [R16] Bit 22 enables priority bits 21:19; the table only stores bits 22:19 as written and applies no enable
module atc_table_command_port #(
    parameter int DEPTH = 64,
    parameter longint AGE_SWEEP_CYCLES = `ATC_AGE_SWEEP_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire atc_pkg::atc_avs_req_s avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Table state
    output logic table_busy
);
    import atc_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    atc_entry_s table_mem [DEPTH];
    logic [2:0] cmd;
    logic [31:0] wr_low;
    logic [31:0] wr_high;
    logic [31:0] rd_low;
    logic [31:0] rd_high;
    logic not_found;
    logic table_full;
    atc_state_e state;
    logic [AW-1:0] idx;
    logic [AW:0] scan_ptr;
    logic hit;
    logic [AW-1:0] hit_idx;
    logic free;
    logic [AW-1:0] free_idx;
    logic [63:0] age_cnt;
    logic age_due;

    logic accept;
    logic [13:0] reg_idx;
    atc_entry_s cur;
    logic cur_match;
    logic cur_free;
    logic last;
    logic next_mem_we;
    logic [AW-1:0] next_mem_addr;
    atc_entry_s next_mem_data;
    logic done;

    assign reg_idx = avs_req.address[15:2];
    assign accept = (avs_req.read || avs_req.write) && !avs_waitrequest;
    assign cur = table_mem[idx];
    assign last = (idx == LAST);
    assign cur_match = cur.high[`ATC_F_VALID]
        && (cur.low == wr_low)
        && (cur.high[`ATC_F_MAC_HI:0] == wr_high[`ATC_F_MAC_HI:0]); // [R7] [R13]
    assign cur_free = !cur.high[`ATC_F_VALID];

    // Bus handshake: one wait cycle, then the request is taken
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_req.read || avs_req.write) && avs_waitrequest);
        end
    end

    // Read data, ready at the edge where the request is taken
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= `ATC_RST_WORD;
        end else if (avs_req.read && avs_waitrequest) begin
            if (reg_idx == `ATC_IDX_CMD) begin
                avs_readdata <= {29'h0000_0000, cmd};
            end else if (reg_idx == `ATC_IDX_WR_LOW) begin
                avs_readdata <= wr_low;
            end else if (reg_idx == `ATC_IDX_WR_HIGH) begin
                avs_readdata <= wr_high;
            end else if (reg_idx == `ATC_IDX_STATUS) begin
                avs_readdata <= {29'h0000_0000, table_full, not_found, |cmd};
            end else if (reg_idx == `ATC_IDX_RD_LOW) begin
                avs_readdata <= rd_low; // [R4]
            end else if (reg_idx == `ATC_IDX_RD_HIGH) begin
                avs_readdata <= rd_high; // [R4]
            end else begin
                avs_readdata <= `ATC_RST_WORD;
            end
        end
    end

    // Write data words
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_low <= `ATC_RST_WORD;
            wr_high <= `ATC_RST_WORD;
        end else if (accept && avs_req.write) begin
            if (reg_idx == `ATC_IDX_WR_LOW) begin
                wr_low <= avs_req.writedata; // [R13]
            end else if (reg_idx == `ATC_IDX_WR_HIGH) begin
                wr_high <= avs_req.writedata & `ATC_WR_HIGH_MASK;
            end
        end
    end

    // Command bits; pending is their OR, so both drop in one edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmd <= `ATC_RST_CMD;
        end else if (done) begin
            cmd <= `ATC_RST_CMD; // [R8]
        end else if (accept && avs_req.write && reg_idx == `ATC_IDX_CMD
                     && cmd == `ATC_RST_CMD) begin // [R1] [R12]
            cmd <= avs_req.writedata[2:0]; // [R2] [R9]
        end
    end

    // Aging sweep request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            age_cnt <= 64'h0;
            age_due <= 1'b0;
        end else begin
            if (age_cnt == 64'(AGE_SWEEP_CYCLES - 1)) begin
                age_cnt <= 64'h0;
                age_due <= 1'b1;
            end else begin
                age_cnt <= age_cnt + 64'h1;
                if (state == ATC_ST_AGE) begin
                    age_due <= 1'b0;
                end
            end
        end
    end

    // Table write port for make and aging
    always_comb begin
        next_mem_we = 1'b0;
        next_mem_addr = idx;
        next_mem_data = wr_high[`ATC_F_VALID] ? {wr_high, wr_low} : '0;
        done = 1'b0;
        case (state)
            ATC_ST_MAKE: begin
                // Match wins, then first free slot, else entry dropped
                if (last) begin
                    done = 1'b1;
                    if (cur_match) begin
                        next_mem_we = 1'b1; // [R7] [R14]
                    end else if (hit) begin
                        next_mem_we = 1'b1; // [R7] [R14]
                        next_mem_addr = hit_idx;
                    end else if (wr_high[`ATC_F_VALID]) begin
                        next_mem_we = free || cur_free; // [R6]
                        next_mem_addr = free ? free_idx : idx;
                    end
                end
            end
            ATC_ST_GET: begin
                done = cur.high[`ATC_F_VALID] || last || scan_ptr > AW'(LAST);
            end
            ATC_ST_AGE: begin
                // Age counts 3, 2, 1, 0, then the entry is cleared
                if (cur.high[`ATC_F_VALID] && !cur.high[`ATC_F_STATIC]) begin // [R15]
                    next_mem_we = 1'b1;
                    next_mem_data = cur;
                    next_mem_data.high[`ATC_F_AGE1] = cur.high[`ATC_F_AGE1] & cur.high[`ATC_F_AGE0];
                    next_mem_data.high[`ATC_F_AGE0] = !cur.high[`ATC_F_AGE0];
                    if (!cur.high[`ATC_F_AGE1] && !cur.high[`ATC_F_AGE0]) begin
                        next_mem_data = '0;
                    end
                end
            end
            default: begin
                done = 1'b0;
            end
        endcase
    end

    // Table storage; priority fields stored as written
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                table_mem[i] <= '0;
            end
        end else if (next_mem_we) begin
            table_mem[next_mem_addr] <= next_mem_data; // [R6] [R16]
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ATC_ST_IDLE;
            idx <= '0;
            hit <= 1'b0;
            hit_idx <= '0;
            free <= 1'b0;
            free_idx <= '0;
        end else begin
            case (state)
                ATC_ST_IDLE: begin
                    // Make before get first, get next, then aging
                    idx <= '0;
                    hit <= 1'b0;
                    free <= 1'b0;
                    if (cmd[`ATC_CMD_MAKE]) begin
                        state <= ATC_ST_MAKE; // [R6]
                    end else if (cmd[`ATC_CMD_FIRST]) begin
                        state <= ATC_ST_GET; // [R10]
                    end else if (cmd[`ATC_CMD_NEXT]) begin
                        state <= ATC_ST_GET; // [R11]
                        idx <= scan_ptr[AW-1:0];
                    end else if (age_due) begin
                        state <= ATC_ST_AGE;
                    end
                end
                ATC_ST_MAKE: begin
                    if (cur_match && !hit) begin
                        hit <= 1'b1;
                        hit_idx <= idx;
                    end
                    if (cur_free && !free) begin
                        free <= 1'b1;
                        free_idx <= idx;
                    end
                    idx <= idx + AW'(1);
                    if (last) begin
                        state <= ATC_ST_IDLE;
                    end
                end
                ATC_ST_GET: begin
                    idx <= idx + AW'(1);
                    if (done) begin
                        state <= ATC_ST_IDLE;
                    end
                end
                default: begin
                    idx <= idx + AW'(1);
                    if (last) begin
                        state <= ATC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Read words, scan pointer and result flags
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_low <= `ATC_RST_WORD;
            rd_high <= `ATC_RST_WORD;
            scan_ptr <= '0;
            not_found <= 1'b0;
            table_full <= 1'b0;
        end else if (state == ATC_ST_GET && done) begin
            if (cur.high[`ATC_F_VALID] && scan_ptr <= AW'(LAST)) begin
                rd_low <= cur.low; // [R4] [R10] [R11]
                rd_high <= cur.high;
                scan_ptr <= {1'b0, idx} + (AW+1)'(1);
                not_found <= 1'b0;
            end else begin
                rd_low <= `ATC_RST_WORD;
                rd_high <= `ATC_RST_WORD;
                // Pointer parks past the end until the next get first
                scan_ptr <= (AW+1)'(DEPTH);
                not_found <= 1'b1;
            end
        end else if (state == ATC_ST_IDLE && cmd[`ATC_CMD_FIRST] && !cmd[`ATC_CMD_MAKE]) begin
            scan_ptr <= '0; // [R10]
        end else if (state == ATC_ST_MAKE && done) begin
            table_full <= !next_mem_we && wr_high[`ATC_F_VALID];
        end
    end

    // Busy indication
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            table_busy <= 1'b0;
        end else begin
            table_busy <= (state != ATC_ST_IDLE) || (|cmd);
        end
    end

endmodule

//--- tb/atc_assertions.sv
`timescale 1ns/1ps
module atc_checker #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register bus
    input wire atc_pkg::atc_avs_req_s avs_req,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Table state
    input wire logic table_busy
);
    import atc_pkg::*;
    localparam int MK_LO = DEPTH + 1;
    localparam int MK_HI = DEPTH + 5;
    logic [13:0] idx;
    logic rd_ok;
    logic cmd_ok;
    assign idx = avs_req.address[15:2];
    assign rd_ok = avs_req.read && !avs_waitrequest;
    assign cmd_ok = avs_req.write && !avs_waitrequest && idx == 14'h1800 && !table_busy;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wait_answer_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("waitrequest not low after request");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    cmd_pending_a: assert property (cmd_ok && |avs_req.writedata[2:0] |-> ##[1:3] table_busy)
        else $error("command did not raise busy");
    zero_cmd_a: assert property (cmd_ok && avs_req.writedata[2:0] == 3'h0
        |=> !table_busy [*3])
        else $error("zero command started work");
    make_done_a: assert property (cmd_ok && avs_req.writedata[2]
        |-> ##[MK_LO:MK_HI] $fell(table_busy))
        else $error("make did not finish in time");
    cmd_clear_a: assert property (rd_ok && idx == 14'h1800 && !table_busy
        && !$past(table_busy) |-> avs_readdata[2:0] == 3'h0)
        else $error("command bits not cleared");
    status_idle_a: assert property (rd_ok && idx == 14'h1803 && !table_busy
        && !$past(table_busy) |-> !avs_readdata[0])
        else $error("pending set while idle");
    reserved_zero_a: assert property (rd_ok && idx == 14'h1800 |-> avs_readdata[31:3] == 29'h0)
        else $error("reserved command bits set");
    unmapped_zero_a: assert property (rd_ok && (idx < 14'h1800 || idx > 14'h1805)
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    make_c: cover property (cmd_ok && avs_req.writedata[2]);
    fetch_c: cover property (rd_ok && idx == 14'h1804);
    zero_c: cover property (cmd_ok && avs_req.writedata[2:0] == 3'h0);
    miss_c: cover property (rd_ok && idx == 14'h1803 && avs_readdata[1]);
endmodule
bind atc_table_command_port atc_checker #(.DEPTH(DEPTH)) chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .table_busy(table_busy));

//--- tb/atc_table_command_port_test.sv
`timescale 1ns/1ps
module atc_table_command_port_test;
    import atc_pkg::*;
    localparam int DEPTH = 16;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    atc_avs_req_s avs_req = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic table_busy;
    int n_fail = 0;
    int n_compared = 0;
    logic [31:0] m_lo [DEPTH];
    logic [31:0] m_hi [DEPTH];
    bit m_v [DEPTH];
    int ptr = 0;
    logic [31:0] q;
    logic [31:0] lo;
    atc_table_command_port #(.DEPTH(DEPTH), .AGE_SWEEP_CYCLES(5000)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .table_busy(table_busy));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
        if (what == "timeout") begin
            final_report();
        end
    endtask
    // Bus cycle: hold the request until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [13:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: d};
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        q = avs_readdata;
        avs_req <= '0;
        if (k >= 20) check("timeout", 32'h1, 32'h0);
    endtask
    // Issue a command and poll the pending flag
    task automatic run(input logic [2:0] c);
        int k;
        k = 0;
        bus(1, 14'h1800, {29'h0, c});
        do begin
            bus(0, 14'h1803, 0);
            k++;
        end while (q[0] !== 1'b0 && k < 40);
        if (k >= 40) check("timeout", 32'h1, 32'h0);
    endtask
    task automatic make(input logic [31:0] l, input logic [31:0] h);
        int mi;
        int fi;
        mi = -1;
        fi = -1;
        bus(1, 14'h1801, l);
        bus(1, 14'h1802, h);
        run(3'h4);
        for (int i = 0; i < DEPTH; i++) begin
            if (m_v[i] && m_lo[i] == l && m_hi[i][15:0] == h[15:0] && mi < 0) mi = i;
            if (!m_v[i] && fi < 0) fi = i;
        end
        check("table_full", {31'h0, mi < 0 && fi < 0 && h[26]}, {31'h0, q[2]});
        if (mi < 0) mi = fi;
        if (mi >= 0) begin
            m_lo[mi] = l;
            m_hi[mi] = h & 32'h07ff_ffff;
            m_v[mi] = h[26];
        end
    endtask
    task automatic get(input bit first);
        int p;
        logic [31:0] el;
        logic [31:0] eh;
        p = DEPTH;
        el = 0;
        eh = 0;
        for (int i = DEPTH - 1; i >= (first ? 0 : ptr + 1); i--) begin
            if (m_v[i]) begin
                el = m_lo[i];
                eh = m_hi[i];
                p = i;
            end
        end
        ptr = p;
        run(first ? 3'h2 : 3'h1);
        check("not_found", {31'h0, p == DEPTH}, {31'h0, q[1]});
        bus(0, 14'h1804, 0);
        check("read_low", el, q);
        bus(0, 14'h1805, 0);
        check("read_high", eh, q);
    endtask
    initial begin
        void'($urandom(32'hc5f42b7a));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(0, 14'(14'h1800 + i), 0);
            check("reset value", 32'h0, q);
        end
        bus(1, 14'h1802, 32'hffff_ffff);
        bus(0, 14'h1802, 0);
        check("write_word_high", 32'h07ff_ffff, q);
        lo = $urandom();
        bus(1, 14'h1801, lo);
        bus(0, 14'h1801, 0);
        check("write_word_low", lo, q);
        get(1);
        for (int i = 0; i < 6; i++) begin
            lo = ($urandom() & 32'hffff_ff00) | 32'(i);
            make(lo, ($urandom() & 32'h03ff_ffff) | 32'h0400_0000);
        end
        make(m_lo[2], m_hi[2] ^ 32'h00f8_0000);
        make(m_lo[4], m_hi[4] & 32'h03ff_ffff);
        bus(1, 14'h1800, 0);
        bus(0, 14'h1803, 0);
        check("pending", 32'h0, {31'h0, q[0]});
        get(1);
        repeat (6) get(0);
        // Fill every free slot, the last make finds the table full
        for (int i = 0; i < 12; i++) begin
            lo = $urandom();
            make(lo, ($urandom() & 32'h03ff_ffff) | 32'h0400_0000);
        end
        // Idle through at least four aging sweeps, then only static entries remain
        repeat (25000) @(posedge ref_clk);
        for (int i = 0; i < DEPTH; i++) begin
            if (m_v[i] && !m_hi[i][24]) m_v[i] = 0;
        end
        get(1);
        repeat (DEPTH) get(0);
        bus(0, 14'h1800, 0);
        check("command bits", 32'h0, q);
        final_report();
    end
endmodule
